// ---- tb/gdp_bank_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module gdp_bank_monitor
  import gdp_pkg::*;
#(
  parameter int unsigned RETRY_LONG  = RETRY_LONG_CYC,
  parameter int unsigned RETRY_SHORT = RETRY_SHORT_CYC,
  parameter int unsigned CAL_CYC     = AUTOCAL_CYC
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // protection
  input wire logic [2:0]  drain_source_overcurrent,
  input wire logic [2:0]  shunt_overcurrent,
  input wire logic [2:0]  bridge_shutdown,
  input wire logic [2:0]  oc_reported,
  input wire gdp_cfg_s    cfg
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic bad_addr;
  assign bad_addr = paddr < 8'h08 || paddr > 8'h20 || paddr[1:0] != 2'h0;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  chk_ready_after_setup: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_err_decode: assert property (s_access |-> pslverr == bad_addr)
    else $error("pslverr wrong for address");
  chk_upper_zero: assert property (s_access |-> prdata[31:11] == 21'h0)
    else $error("upper read bits set");
  chk_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("bus outputs not quiet");
  // decoded defaults must already stand at the first edge out of reset
  chk_cfg_defaults: assert property ($rose(presetn) |-> cfg.hold_cyc == 9'd400 &&
    cfg.src_ma == 11'd1000 && cfg.snk_ma == 11'd1900 && cfg.dead_cyc == 6'd10 &&
    cfg.trip_mv == 11'd600 && cfg.filt_cyc == 10'd400 && cfg.ref_div &&
    cfg.gain == 2'h2 && cfg.shunt_trip == 2'h3 && !cfg.in_sel && !cfg.low_side_measure_reference)
    else $error("decoded defaults wrong");
  chk_report_filtered: assert property ($rose(oc_reported[0]) |->
    $past(drain_source_overcurrent[0], 60) || $past(shunt_overcurrent[0], 60))
    else $error("report without filtered condition");
  chk_shut_after_rep: assert property ($rose(|bridge_shutdown) |->
    $past(oc_reported) != 3'h0)
    else $error("shutdown without prior report");
endmodule // gdp_bank_monitor
bind gdp_bank gdp_bank_monitor #(
  .RETRY_LONG(RETRY_LONG), .RETRY_SHORT(RETRY_SHORT), .CAL_CYC(CAL_CYC)
) u_gdp_bank_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .drain_source_overcurrent(drain_source_overcurrent),
  .shunt_overcurrent(shunt_overcurrent), .bridge_shutdown(bridge_shutdown),
  .oc_reported(oc_reported), .cfg(cfg)
);
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
  import gdp_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  drain_oc, shunt_oc, pwm, shut, rep, cal_short;
  gdp_cfg_s    cfg;
  int          n_fail, n_tests, cyc;
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  // short retry and calibration counts keep the run brief
  gdp_bank #(.RETRY_LONG(200), .RETRY_SHORT(50), .CAL_CYC(20)) u_gdp_bank (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drain_source_overcurrent(drain_oc), .shunt_overcurrent(shunt_oc), .pwm_pin(pwm),
    .bridge_shutdown(shut), .oc_reported(rep), .cfg(cfg), .amp_input_short(cal_short)
  );
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report;
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edges let the decoded settings land before anyone looks
    repeat (3) @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic oc(input logic [2:0] d, input logic [2:0] s);
    drain_oc <= d;
    shunt_oc <= s;
    repeat (120) @(posedge pclk);
    drain_oc <= 3'h0;
    shunt_oc <= 3'h0;
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {drain_oc, shunt_oc, pwm} = '0;
    {n_fail, n_tests, cyc} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(8'h10, 32'h7ff);
    rdc(8'h14, 32'h169);
    rdc(8'h18, 32'h283);
    rdc(8'h1c, 32'h0);
    rdc(8'h0c, 32'h300);
    apb(1'b0, 8'h04, 32'h0);
    chk({er, rd}, 33'h100000000);
    apb(1'b1, 8'h24, 32'h7ff);
    chk(er, 1'b1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h10, 32'(i << 8));
      apb(1'b1, 8'h14, 32'((i << 8) | (i << 4) | 'h49));
      apb(1'b1, 8'h18, 32'((i << 6) | i));
      chk(cfg.hold_cyc, 32'(50 << i));
      chk(cfg.dead_cyc, 32'(5 << i));
      chk(cfg.filt_cyc, 32'(100 << i));
      chk({cfg.gain, cfg.shunt_trip}, {i[1:0], i[1:0]});
    end
    chk({cfg.src_ma, cfg.snk_ma, cfg.trip_mv}, {11'd50, 11'd100, 11'd600});
    rdc(8'h10, 32'h300);
    apb(1'b1, 8'h10, 32'h011);
    chk({cfg.src_ma, cfg.snk_ma}, {11'd50, 11'd100});
    apb(1'b1, 8'h18, 32'h400);
    rdc(8'h18, 32'h500);
    chk({cfg.in_sel, cfg.low_side_measure_reference}, 2'h3);
    apb(1'b1, 8'h18, 32'h320);
    chk({cfg.in_sel, cfg.ref_div, cfg.low_side_measure_reference, cfg.shunt_dis}, 4'h7);
    apb(1'b1, 8'h18, 32'h010);
    chk(cal_short, 3'h4);
    apb(1'b1, 8'h18, 32'h01c);
    chk(cal_short, 3'h7);
    apb(1'b1, 8'h18, 32'h0);
    chk({cal_short, cfg.ref_div, cfg.low_side_measure_reference}, 5'h0);
    apb(1'b1, 8'h1c, 32'h1);
    chk(cal_short, 3'h7);
    rdc(8'h20, 32'h40);
    repeat (30) @(posedge pclk);
    chk(cal_short, 3'h0);
    apb(1'b1, 8'h0c, 32'h600);
    apb(1'b1, 8'h10, 32'h7ff);
    rdc(8'h10, 32'h011);
    apb(1'b1, 8'h0c, 32'h500);
    rdc(8'h0c, 32'h600);
    apb(1'b1, 8'h08, 32'h406);
    rdc(8'h08, 32'h006);
    rdc(8'h20, 32'h80);
    apb(1'b1, 8'h0c, 32'h300);
    apb(1'b1, 8'h10, 32'h400);
    rdc(8'h10, 32'h400);
    apb(1'b1, 8'h14, 32'h009);
    drain_oc <= 3'h1;
    repeat (80) @(posedge pclk);
    chk(rep, 3'h0);
    repeat (40) @(posedge pclk);
    chk({shut, rep}, 6'h09);
    rdc(8'h20, 32'h09);
    drain_oc <= 3'h0;
    pwm      <= 3'h1;
    repeat (300) @(posedge pclk);
    chk(shut, 3'h1);
    apb(1'b1, 8'h08, 32'h1);
    chk({shut, rep}, 6'h0);
    rdc(8'h08, 32'h0);
    apb(1'b1, 8'h14, 32'h089);
    oc(3'h0, 3'h2);
    chk({shut, rep}, 6'h02);
    apb(1'b1, 8'h18, 32'h020);
    oc(3'h0, 3'h4);
    chk(rep, 3'h2);
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b1, 8'h14, 32'h0c9);
    oc(3'h4, 3'h0);
    chk({shut, rep}, 6'h0);
    apb(1'b1, 8'h14, 32'h049);
    apb(1'b1, 8'h08, 32'h400);
    pwm <= 3'h0;
    oc(3'h1, 3'h0);
    chk(shut, 3'h7);
    pwm <= 3'h1;
    repeat (8) @(posedge pclk);
    chk(shut, 3'h0);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h08, 32'h0);
    pwm <= 3'h0;
    oc(3'h1, 3'h0);
    chk(shut, 3'h1);
    pwm <= 3'h1;
    repeat (60) @(posedge pclk);
    chk(shut, 3'h1);
    repeat (150) @(posedge pclk);
    chk(shut, 3'h0);
    apb(1'b1, 8'h14, 32'h449);
    oc(3'h1, 3'h0);
    chk(shut, 3'h1);
    repeat (50) @(posedge pclk);
    chk(shut, 3'h0);
    final_report;
  end
endmodule // testbench
`default_nettype wire

// ---- verilog/gdp_bank.sv ----
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gdp_bank
  import gdp_pkg::*;
#(
  parameter int unsigned RETRY_LONG  = RETRY_LONG_CYC,
  parameter int unsigned RETRY_SHORT = RETRY_SHORT_CYC,
  parameter int unsigned CAL_CYC     = AUTOCAL_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // overcurrent comparators and pwm inputs, asynchronous pins
  input  wire logic [2:0]  drain_source_overcurrent,
  input  wire logic [2:0]  shunt_overcurrent,
  input  wire logic [2:0]  pwm_pin,
  // protection results
  output var  logic [2:0]  bridge_shutdown,
  output var  logic [2:0]  oc_reported,
  // analog settings
  output var  gdp_cfg_s    cfg,
  output var  logic [2:0]  amp_input_short
);

  typedef struct packed {
    logic [10:0]      gate_ls;
    logic [10:0]      ocp;
    logic [10:0]      amp;
    logic [10:0]      cal;
    logic             scope;
    logic [2:1]       drv_low;
    logic             locked;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic [8:0]       s1;
    logic [8:0]       s2;
    logic [8:0]       s3;
    logic [8:0]       filt;
    logic [2:0][9:0]  deg;
    logic [2:0]       flt;
    logic [2:0]       rep;
    logic [19:0]      retry;
    gdp_cal_e         cal_st;
    logic [15:0]      cal_cnt;
    logic [2:0]       shut;
    logic [2:0]       cal_short;
    gdp_cfg_s         cfg;
  } gdp_state_s;

  // codes 0 and 1 share the lowest step
  function automatic logic [10:0] src_lut(input logic [3:0] c);
    logic [10:0] v;
    v = 11'h000;
    unique case (c)
      4'h0, 4'h1: v = 11'h032;
      4'h2: v = 11'h064;
      4'h3: v = 11'h096;
      4'h4: v = 11'h12c;
      4'h5: v = 11'h15e;
      4'h6: v = 11'h190;
      4'h7: v = 11'h1c2;
      4'h8: v = 11'h226;
      4'h9: v = 11'h258;
      4'ha: v = 11'h28a;
      4'hb: v = 11'h2bc;
      4'hc: v = 11'h352;
      4'hd: v = 11'h384;
      4'he: v = 11'h3b6;
      4'hf: v = 11'h3e8;
    endcase
    return v;
  endfunction

  function automatic logic [10:0] snk_lut(input logic [3:0] c);
    logic [10:0] v;
    v = 11'h000;
    unique case (c)
      4'h0, 4'h1: v = 11'h064;
      4'h2: v = 11'h0c8;
      4'h3: v = 11'h12c;
      4'h4: v = 11'h258;
      4'h5: v = 11'h2bc;
      4'h6: v = 11'h320;
      4'h7: v = 11'h384;
      4'h8: v = 11'h44c;
      4'h9: v = 11'h4b0;
      4'ha: v = 11'h514;
      4'hb: v = 11'h578;
      4'hc: v = 11'h6a4;
      4'hd: v = 11'h708;
      4'he: v = 11'h73a;
      4'hf: v = 11'h76c;
    endcase
    return v;
  endfunction

  function automatic logic [10:0] trip_lut(input logic [3:0] c);
    logic [10:0] v;
    v = 11'h000;
    unique case (c)
      4'h0: v = 11'h03c;
      4'h1: v = 11'h046;
      4'h2: v = 11'h050;
      4'h3: v = 11'h05a;
      4'h4: v = 11'h064;
      4'h5: v = 11'h0c8;
      4'h6: v = 11'h12c;
      4'h7: v = 11'h190;
      4'h8: v = 11'h1f4;
      4'h9: v = 11'h258;
      4'ha: v = 11'h2bc;
      4'hb: v = 11'h320;
      4'hc: v = 11'h384;
      4'hd: v = 11'h3e8;
      4'he: v = 11'h5dc;
      4'hf: v = 11'h7d0;
    endcase
    return v;
  endfunction

  // every timed field doubles per code step
  function automatic gdp_cfg_s cfg_of(input logic [10:0] gl, input logic [10:0] oc,
                                      input logic [10:0] am);
    gdp_cfg_s c;
    c            = '0;
    c.hold_cyc   = 9'(HOLD_CYC_BASE << gl[B_HOLD +: 2]);
    c.src_ma     = src_lut(gl[B_SRC +: 4]);
    c.snk_ma     = snk_lut(gl[B_SNK +: 4]);
    c.dead_cyc   = 6'(DEAD_CYC_BASE << oc[B_DEAD +: 2]);
    c.trip_mv    = trip_lut(oc[B_TRIP +: 4]);
    c.filt_cyc   = 10'(FILT_CYC_BASE << oc[B_FILT +: 2]);
    c.in_sel     = am[B_INSEL];
    c.ref_div    = am[B_REFDIV];
    c.low_side_measure_reference     = am[B_LSREF];
    c.gain       = am[B_GAIN +: 2];
    c.shunt_dis  = am[B_SDIS];
    c.shunt_trip = am[B_STRIP +: 2];
    return c;
  endfunction

  // returns index and a valid flag
  // lock word below and status word above the configuration words
  function automatic logic [6:0] decode(input logic [7:0] a);
    logic ok;
    ok = (a[1:0] == 2'h0) && (a[7:2] >= IDX_DRV_CTRL) && (a[7:2] <= IDX_STATUS);
    return {ok, a[7:2]};
  endfunction

  localparam gdp_cfg_s CFG_RST = cfg_of(GATE_LS_RST, OCP_RST, AMP_RST);

  gdp_state_s s_r;
  gdp_state_s s_nxt;

  logic [6:0]  dec;
  logic        wr;
  logic [2:0]  cond;
  logic [2:0]  event_p;
  logic [2:0]  pwm_rise;
  logic        clr_cmd;
  logic        retry_done;
  logic        act_mode;
  logic [31:0] rd;

  always_comb begin
    s_nxt = s_r;
    dec   = decode(paddr);
    wr    = psel && penable && pwrite && s_r.pready && !s_r.pslverr;
    rd    = 32'h0000_0000;

    // three-stage pin sampling, a change counts once stages two and three agree
    // agreement of the last two stages also drops a one-cycle glitch
    s_nxt.s1 = {pwm_pin, shunt_overcurrent, drain_source_overcurrent};
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    for (int i = 0; i < 9; i++) begin
      if (s_r.s2[i] == s_r.s3[i]) begin
        s_nxt.filt[i] = s_r.s3[i];
      end
    end
    pwm_rise = s_nxt.filt[8:6] & ~s_r.filt[8:6];

    // one-cycle answer: setup cycle prepares data, access cycle shows ready
    // registered answer keeps every bus output on a flop at no extra wait
    s_nxt.pready  = psel && !penable;
    s_nxt.pslverr = psel && !penable && !dec[6];
    if (psel && !penable && dec[6]) begin
      unique case (dec[5:0])
        IDX_DRV_CTRL: rd = {21'h0, s_r.scope, 7'h0, s_r.drv_low, 1'b0};
        IDX_LOCK:     rd = {21'h0, s_r.locked ? LOCK_CLOSE : LOCK_OPEN, 8'h0};
        IDX_GATE_LS:  rd = {21'h0, s_r.gate_ls};
        IDX_OCP:      rd = {21'h0, s_r.ocp};
        IDX_AMP:      rd = {21'h0, s_r.amp};
        IDX_CAL:      rd = {21'h0, s_r.cal};
        default:      rd = {24'h0, s_r.locked, s_r.cal_st == GDP_CAL_RUN, s_r.rep, s_r.flt};
      endcase
    end
    s_nxt.prdata = rd;

    // register writes; locking leaves the lock field and three control bits open
    // a locked bank drops writes silently; no bus error is raised
    clr_cmd = 1'b0;
    if (wr) begin
      unique case (dec[5:0])
        IDX_DRV_CTRL: begin
          s_nxt.drv_low = pwdata[2:1];
          clr_cmd       = pwdata[B_CLR];
          if (!s_r.locked) begin
            s_nxt.scope = pwdata[B_SCOPE];
          end
        end
        IDX_LOCK: begin
          if (!s_r.locked && pwdata[B_LOCK +: 3] == LOCK_CLOSE) begin
            s_nxt.locked = 1'b1;
          end else if (s_r.locked && pwdata[B_LOCK +: 3] == LOCK_OPEN) begin
            s_nxt.locked = 1'b0;
          end
        end
        IDX_GATE_LS: begin
          if (!s_r.locked) begin
            s_nxt.gate_ls = pwdata[10:0];
          end
        end
        IDX_OCP: begin
          if (!s_r.locked) begin
            s_nxt.ocp = pwdata[10:0];
          end
        end
        IDX_AMP: begin
          if (!s_r.locked) begin
            s_nxt.amp = pwdata[10:0];
            if (pwdata[B_INSEL]) begin
              s_nxt.amp[B_LSREF] = 1'b1;
            end
          end
        end
        IDX_CAL: begin
          if (!s_r.locked) begin
            s_nxt.cal = pwdata[10:0];
          end
        end
        default: begin
        end
      endcase
    end
    s_nxt.cfg = cfg_of(s_r.gate_ls, s_r.ocp, s_r.amp);

    // deglitch: count while the condition holds, fire once at the limit
    // the count stops at the limit, so a long overcurrent raises one event
    act_mode = s_r.ocp[B_MODE +: 2] == MODE_LATCH || s_r.ocp[B_MODE +: 2] == MODE_RETRY;
    for (int p = 0; p < 3; p++) begin
      cond[p]    = s_r.filt[p] || (s_r.filt[3 + p] && !s_r.amp[B_SDIS]);
      event_p[p] = 1'b0;
      if (!cond[p]) begin
        s_nxt.deg[p] = 10'h000;
      end else if (s_r.deg[p] < s_r.cfg.filt_cyc) begin
        s_nxt.deg[p] = s_r.deg[p] + 10'h001;
        event_p[p]   = (s_r.deg[p] == s_r.cfg.filt_cyc - 10'h001);
      end
    end

    // retry timer, loaded on each new event in automatic mode
    // limitation: one shared timer, a later event restarts it for every phase
    retry_done = (s_r.retry == 20'h00001);
    if (s_r.retry != 20'h00000) begin
      s_nxt.retry = s_r.retry - 20'h00001;
    end
    if (s_r.ocp[B_MODE +: 2] == MODE_RETRY && |event_p) begin
      s_nxt.retry = s_r.ocp[B_RETRY] ? 20'(RETRY_SHORT) : 20'(RETRY_LONG);
    end

    // clearing first, so an event in the same cycle still wins
    if (clr_cmd) begin
      s_nxt.flt = 3'h0;
      s_nxt.rep = 3'h0;
    end
    if (s_r.ocp[B_MODE +: 2] == MODE_RETRY) begin
      if (retry_done) begin
        s_nxt.flt = 3'h0;
      end
      if (s_r.gate_ls[B_CBC] && |pwm_rise) begin
        s_nxt.flt = 3'h0;
      end
    end
    if (act_mode) begin
      s_nxt.flt = s_nxt.flt | event_p;
    end
    if (act_mode || s_r.ocp[B_MODE +: 2] == MODE_REPORT) begin
      s_nxt.rep = s_nxt.rep | event_p;
    end

    // shutdown follows the fault bits, widened by the scope bit
    // one cycle behind the fault bits so the output stays a plain flop
    s_nxt.shut = (s_r.scope && |s_r.flt) ? 3'h7 : s_r.flt;

    // automatic calibration starts when the mode bit is set
    // leaving automatic mode aborts a running routine at once
    unique case (s_r.cal_st)
      GDP_CAL_IDLE: begin
        if (wr && dec[5:0] == IDX_CAL && !s_r.locked && pwdata[B_CALMODE] &&
            !s_r.cal[B_CALMODE]) begin
          s_nxt.cal_st  = GDP_CAL_RUN;
          s_nxt.cal_cnt = 16'(CAL_CYC);
        end
      end
      GDP_CAL_RUN: begin
        s_nxt.cal_cnt = s_r.cal_cnt - 16'h0001;
        if (s_r.cal_cnt == 16'h0001 || !s_r.cal[B_CALMODE]) begin
          s_nxt.cal_st  = GDP_CAL_IDLE;
          s_nxt.cal_cnt = 16'h0000;
        end
      end
    endcase
    // manual bits only count outside automatic mode
    if (s_r.cal[B_CALMODE]) begin
      s_nxt.cal_short = (s_r.cal_st == GDP_CAL_RUN) ? 3'h7 : 3'h0;
    end else begin
      s_nxt.cal_short = s_r.amp[B_CALA -: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r         <= '0;
      s_r.gate_ls <= GATE_LS_RST;
      s_r.ocp     <= OCP_RST;
      s_r.amp     <= AMP_RST;
      s_r.cal     <= CAL_RST;
      s_r.cal_st  <= GDP_CAL_IDLE;
      // decoded defaults, so the analog side never sees all zeros
      s_r.cfg     <= CFG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata          = s_r.prdata;
  assign pready          = s_r.pready;
  assign pslverr         = s_r.pslverr;
  assign bridge_shutdown = s_r.shut;
  assign oc_reported     = s_r.rep;
  assign cfg             = s_r.cfg;
  assign amp_input_short = s_r.cal_short;

endmodule // gdp_bank
`default_nettype wire

// ---- verilog/gdp_pkg.sv ----
`default_nettype none
package gdp_pkg;
  // clock rate for every time-to-cycle conversion
  localparam int unsigned CLK_MHZ = 100;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_DRV_CTRL  = 6'h02;
  localparam logic [5:0] IDX_LOCK      = 6'h03;
  localparam logic [5:0] IDX_GATE_LS   = 6'h04;
  localparam logic [5:0] IDX_OCP       = 6'h05;
  localparam logic [5:0] IDX_AMP       = 6'h06;
  localparam logic [5:0] IDX_CAL       = 6'h07;
  localparam logic [5:0] IDX_STATUS    = 6'h08;
  // reset values of the eleven-bit registers, then the two lock codes
  localparam logic [10:0] GATE_LS_RST  = 11'h7ff;
  localparam logic [10:0] OCP_RST      = 11'h169;
  localparam logic [10:0] AMP_RST      = 11'h283;
  localparam logic [10:0] CAL_RST      = 11'h000;
  localparam logic [2:0]  LOCK_OPEN    = 3'h3;
  localparam logic [2:0]  LOCK_CLOSE   = 3'h6;
  // field positions
  localparam int unsigned B_CBC        = 10;
  localparam int unsigned B_HOLD       = 8;
  localparam int unsigned B_SRC        = 4;
  localparam int unsigned B_SNK        = 0;
  localparam int unsigned B_RETRY      = 10;
  localparam int unsigned B_DEAD       = 8;
  localparam int unsigned B_MODE       = 6;
  localparam int unsigned B_FILT       = 4;
  localparam int unsigned B_TRIP       = 0;
  localparam int unsigned B_INSEL      = 10;
  localparam int unsigned B_REFDIV     = 9;
  localparam int unsigned B_LSREF      = 8;
  localparam int unsigned B_GAIN       = 6;
  localparam int unsigned B_SDIS       = 5;
  localparam int unsigned B_CALA       = 4;
  localparam int unsigned B_STRIP      = 0;
  localparam int unsigned B_CALMODE    = 0;
  localparam int unsigned B_SCOPE      = 10;
  localparam int unsigned B_LOCK       = 8;
  localparam int unsigned B_CLR        = 0;
  // response modes
  localparam logic [1:0] MODE_LATCH    = 2'h0;
  localparam logic [1:0] MODE_RETRY    = 2'h1;
  localparam logic [1:0] MODE_REPORT   = 2'h2;
  // timing figures and cycle counts
  localparam int unsigned FILT_NS_BASE = 1000;
  localparam int unsigned FILT_CYC_BASE = FILT_NS_BASE * CLK_MHZ / 1000;
  localparam int unsigned DEAD_NS_BASE = 50;
  localparam int unsigned DEAD_CYC_BASE = DEAD_NS_BASE * CLK_MHZ / 1000;
  localparam int unsigned HOLD_NS_BASE = 500;
  localparam int unsigned HOLD_CYC_BASE = HOLD_NS_BASE * CLK_MHZ / 1000;
  localparam int unsigned RETRY_LONG_US = 8000;
  localparam int unsigned RETRY_LONG_CYC = RETRY_LONG_US * CLK_MHZ;
  localparam int unsigned RETRY_SHORT_US = 50;
  localparam int unsigned RETRY_SHORT_CYC = RETRY_SHORT_US * CLK_MHZ;
  localparam int unsigned AUTOCAL_US   = 10;
  localparam int unsigned AUTOCAL_CYC  = AUTOCAL_US * CLK_MHZ;

  typedef enum logic [1:0] {
    GDP_CAL_IDLE = 2'b01,
    GDP_CAL_RUN  = 2'b10
  } gdp_cal_e;

  // decoded settings handed to the analog side
  typedef struct packed {
    logic [8:0]  hold_cyc;
    logic [10:0] src_ma;
    logic [10:0] snk_ma;
    logic [5:0]  dead_cyc;
    logic [10:0] trip_mv;
    logic [9:0]  filt_cyc;
    logic        in_sel;
    logic        ref_div;
    logic        low_side_measure_reference;
    logic [1:0]  gain;
    logic        shunt_dis;
    logic [1:0]  shunt_trip;
  } gdp_cfg_s;
endpackage
`default_nettype wire
